/* File: design/arsup_top.sv */
// autoreclose supervision: rate, current and zone coordination
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module arsup_top #(
	parameter int CUR_W = 12,
	parameter int DEPTH = 64,
	parameter int SECOND_CYCLES = arsup_pkg::SECOND_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CUR_W-1:0] cur_a,
	input wire logic [CUR_W-1:0] cur_b,
	input wire logic [CUR_W-1:0] cur_c,
	input wire logic [CUR_W-1:0] cur_n,
	input wire logic meas_valid,
	input wire logic trip_start,
	input wire logic reclose_done,
	output logic lockout,
	output logic [2:0] shot_count,
	output logic [2:0] shot_limit,
	output logic rate_alarm,
	output logic [4:0] aux_relay,
	output logic next_shot_apply,
	output logic reset_timer_run
);
	localparam int SW = $clog2(SECOND_CYCLES);
	localparam int CW = $clog2(DEPTH + 1);

	////////////////////////////////////////////////////////////////////////
	// setting clamps, out-of-range writes pull to nearest legal value
	function automatic logic [11:0] clamp12(input logic [31:0] v,
		input int lo, input int hi);
		if (v < 32'(lo)) begin
			return 12'(lo);
		end else if (v > 32'(hi)) begin
			return 12'(hi);
		end
		return v[11:0];
	endfunction

	// apb decode, always zero wait in access phase
	wire setup = psel && !penable;
	wire wr_en = psel && penable && pwrite;
	wire a_ctrl = paddr == arsup_pkg::OFF_CTRL;
	wire a_rate = paddr == arsup_pkg::OFF_RATE;
	wire a_cs3 = paddr == arsup_pkg::OFF_CS3;
	wire a_cs2 = paddr == arsup_pkg::OFF_CS2;
	wire a_cs1 = paddr == arsup_pkg::OFF_CS1;
	wire a_cslo = paddr == arsup_pkg::OFF_CSLO;
	wire a_zcph = paddr == arsup_pkg::OFF_ZC_PH;
	wire a_zcn = paddr == arsup_pkg::OFF_ZC_N;
	wire a_tmax = paddr == arsup_pkg::OFF_ZC_TMAX;
	wire a_arr = paddr == arsup_pkg::OFF_AR_RESET;
	wire a_stat = paddr == arsup_pkg::OFF_STATUS;
	wire a_cmd = paddr == arsup_pkg::OFF_CMD;
	wire mapped = a_ctrl | a_rate | a_cs3 | a_cs2 | a_cs1 | a_cslo |
		a_zcph | a_zcn | a_tmax | a_arr | a_stat | a_cmd;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// settings registers
	logic [1:0] mode_r; // rate supervision mode
	logic cs_en_r; // current supervision enable
	logic oclo_en_r; // overcurrent_lockout_enable
	logic zc_en_r; // zone coordination enable
	logic [2:0] max_shots_r; // configured shot maximum
	logic [4:0] relay_sel_r; // aux relays 3..7
	logic [5:0] max_rate_r; // recloses per hour
	logic [11:0] cs3_r, cs2_r, cs1_r, cslo_r; // hundredths of CT
	logic [11:0] zc_ph_r, zc_n_r; // step sizes
	logic [9:0] zc_tmax_r, ar_reset_r; // seconds

	// register writes with range clamping
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_r <= 2'h0;
			cs_en_r <= 1'b0;
			oclo_en_r <= 1'b0;
			zc_en_r <= 1'b0;
			max_shots_r <= arsup_pkg::RST_SHOTS;
			relay_sel_r <= 5'h00;
			max_rate_r <= arsup_pkg::RST_MAX_RATE;
			cs3_r <= arsup_pkg::RST_CS3;
			cs2_r <= arsup_pkg::RST_CS2;
			cs1_r <= arsup_pkg::RST_CS1;
			cslo_r <= arsup_pkg::RST_CSLO;
			zc_ph_r <= arsup_pkg::RST_ZC_STEP;
			zc_n_r <= arsup_pkg::RST_ZC_STEP;
			zc_tmax_r <= arsup_pkg::RST_ZC_TMAX;
			ar_reset_r <= arsup_pkg::RST_AR_RESET;
		end else if (wr_en) begin
			if (a_ctrl) begin
				mode_r <= pwdata[arsup_pkg::CTRL_MODE_LSB +: 2];
				cs_en_r <= pwdata[arsup_pkg::CTRL_CS_EN];
				oclo_en_r <= pwdata[arsup_pkg::CTRL_OCLO_EN];
				zc_en_r <= pwdata[arsup_pkg::CTRL_ZC_EN];
				max_shots_r <= 3'(clamp12(
					32'(pwdata[arsup_pkg::CTRL_SHOTS_LSB +: 3]),
					arsup_pkg::SHOTS_MIN, arsup_pkg::SHOTS_MAX));
				relay_sel_r <= pwdata[arsup_pkg::CTRL_RELAY_LSB +: 5];
			end
			if (a_rate) begin
				max_rate_r <= 6'(clamp12(pwdata, arsup_pkg::RATE_MIN,
					arsup_pkg::RATE_MAX));
			end
			// thresholds 0.00..20.00 in hundredths
			if (a_cs3) cs3_r <= clamp12(pwdata, 0, arsup_pkg::THR_MAX);
			if (a_cs2) cs2_r <= clamp12(pwdata, 0, arsup_pkg::THR_MAX);
			if (a_cs1) cs1_r <= clamp12(pwdata, 0, arsup_pkg::THR_MAX);
			if (a_cslo) cslo_r <= clamp12(pwdata, 0, arsup_pkg::THR_MAX);
			if (a_zcph) begin
				zc_ph_r <= clamp12(pwdata, arsup_pkg::STEP_MIN,
					arsup_pkg::THR_MAX);
			end
			if (a_zcn) begin
				zc_n_r <= clamp12(pwdata, arsup_pkg::STEP_MIN,
					arsup_pkg::THR_MAX);
			end
			if (a_tmax) begin
				zc_tmax_r <= 10'(clamp12(pwdata, arsup_pkg::TIME_MIN,
					arsup_pkg::TIME_MAX));
			end
			if (a_arr) begin
				ar_reset_r <= 10'(clamp12(pwdata, arsup_pkg::TIME_MIN,
					arsup_pkg::TIME_MAX));
			end
		end
	end

	// command strobes, one cycle
	wire clr_alarm = wr_en && a_cmd && pwdata[arsup_pkg::CMD_CLR_ALARM];
	wire clr_lock = wr_en && a_cmd && pwdata[arsup_pkg::CMD_CLR_LOCKOUT];

	////////////////////////////////////////////////////////////////////////
	// one second enable from the system clock
	logic [SW-1:0] div_r;
	wire sec_tick = div_r == SW'(SECOND_CYCLES - 1);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			div_r <= '0;
		end else begin
			div_r <= sec_tick ? '0 : div_r + SW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sliding hour: one age counter per remembered reclose
	// depth must exceed the largest rate so an over-limit count is seen
	logic [DEPTH-1:0] ev_valid_r;
	logic [11:0] ev_age_r [DEPTH];
	logic [DEPTH-1:0] slot_onehot;
	logic [CW-1:0] rate_count;
	always_comb begin
		logic found;
		found = 1'b0;
		slot_onehot = '0;
		rate_count = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if (!ev_valid_r[i] && !found) begin
				slot_onehot[i] = 1'b1;
				found = 1'b1;
			end
			rate_count = rate_count + CW'(ev_valid_r[i]);
		end
	end
	generate
		for (genvar g = 0; g < DEPTH; g++) begin : g_ev
			wire expire = sec_tick && ev_age_r[g] ==
				12'(arsup_pkg::RATE_WINDOW_S - 1);
			// each entry ages out after sixty minutes
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					ev_valid_r[g] <= 1'b0;
					ev_age_r[g] <= 12'h000;
				end else if (reclose_done && slot_onehot[g]) begin
					ev_valid_r[g] <= 1'b1;
					ev_age_r[g] <= 12'h000;
				end else if (expire) begin
					ev_valid_r[g] <= 1'b0;
				end else if (sec_tick && ev_valid_r[g]) begin
					ev_age_r[g] <= ev_age_r[g] + 12'h001;
				end
			end
		end
	endgenerate

	// rate element operates when the hourly count exceeds the limit
	wire rate_over = rate_count > CW'(max_rate_r);
	wire rate_op = mode_r != arsup_pkg::RATE_OFF && rate_over;
	wire rate_trip = mode_r == arsup_pkg::RATE_CONTROL && rate_over;
	logic alarm_latch_r; // latched alarm, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alarm_latch_r <= 1'b0;
		end else if (mode_r == arsup_pkg::RATE_LATCHED && rate_over) begin
			alarm_latch_r <= 1'b1;
		end else if (clr_alarm || mode_r != arsup_pkg::RATE_LATCHED) begin
			alarm_latch_r <= 1'b0;
		end
	end
	// relays follow the element, registered to keep data outputs clean
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aux_relay <= 5'h00;
			rate_alarm <= 1'b0;
		end else begin
			aux_relay <= relay_sel_r & {5{rate_op || alarm_latch_r}};
			rate_alarm <= rate_op || alarm_latch_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peak of the three phases
	wire [CUR_W-1:0] pk_ab = cur_a > cur_b ? cur_a : cur_b;
	wire [CUR_W-1:0] peak = pk_ab > cur_c ? pk_ab : cur_c;
	// shots allowed by fault level, four means no cut
	wire [2:0] cs_derived = peak > CUR_W'(cs1_r) ? 3'h1 :
		peak > CUR_W'(cs2_r) ? 3'h2 :
		peak > CUR_W'(cs3_r) ? 3'h3 : 3'h4;
	wire cs_lock = trip_start && cs_en_r && oclo_en_r &&
		peak > CUR_W'(cslo_r);

	// current limit and effective limit
	logic [2:0] cs_limit_r;
	wire [2:0] eff_limit = cs_limit_r < max_shots_r ? cs_limit_r :
		max_shots_r;

	////////////////////////////////////////////////////////////////////////
	// coordination detector: remembered rise awaits a fall
	arsup_pkg::arsup_zc_state_e zc_state_r;
	logic [CUR_W-1:0] prev_pk_r, prev_n_r;
	logic [9:0] zc_age_r; // seconds since the rise
	wire ph_rise = peak > prev_pk_r &&
		(peak - prev_pk_r) >= CUR_W'(zc_ph_r);
	wire n_rise = cur_n > prev_n_r && (cur_n - prev_n_r) >= CUR_W'(zc_n_r);
	wire ph_fall = prev_pk_r > peak &&
		(prev_pk_r - peak) >= CUR_W'(zc_ph_r);
	wire n_fall = prev_n_r > cur_n && (prev_n_r - cur_n) >= CUR_W'(zc_n_r);
	wire zc_stale = sec_tick && zc_age_r >= zc_tmax_r - 10'h001;
	wire ext_reclose = zc_en_r && zc_state_r == arsup_pkg::ZC_RISEN &&
		meas_valid && (ph_fall || n_fall);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			zc_state_r <= arsup_pkg::ZC_IDLE;
			prev_pk_r <= '0;
			prev_n_r <= '0;
			zc_age_r <= 10'h000;
		end else begin
			if (meas_valid) begin
				prev_pk_r <= peak;
				prev_n_r <= cur_n;
			end
			case (zc_state_r)
				arsup_pkg::ZC_IDLE: begin
					zc_age_r <= 10'h000;
					if (zc_en_r && meas_valid && (ph_rise || n_rise)) begin
						zc_state_r <= arsup_pkg::ZC_RISEN;
					end
				end
				arsup_pkg::ZC_RISEN: begin
					// load growth never falls back, so forget it
					if (!zc_en_r || ext_reclose || zc_stale) begin
						zc_state_r <= arsup_pkg::ZC_IDLE;
					end else if (sec_tick) begin
						zc_age_r <= zc_age_r + 10'h001;
					end
				end
				default: zc_state_r <= arsup_pkg::ZC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// autoreclose reset timer, one fault event long
	logic [9:0] ar_cnt_r;
	logic ar_run_r;
	wire ar_expire = ar_run_r && sec_tick && ar_cnt_r == 10'h001;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ar_run_r <= 1'b0;
			ar_cnt_r <= 10'h000;
		end else if (!ar_run_r && (trip_start || ext_reclose)) begin
			ar_run_r <= 1'b1;
			ar_cnt_r <= ar_reset_r;
		end else if (ar_expire) begin
			ar_run_r <= 1'b0;
		end else if (ar_run_r && sec_tick) begin
			ar_cnt_r <= ar_cnt_r - 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shot counter, current limit and lockout
	wire own_shot = reclose_done && !lockout;
	wire [2:0] count_inc = shot_count + 3'h1;
	wire shots_spent = trip_start && shot_count >= eff_limit;
	wire ext_spent = ext_reclose && count_inc >= max_shots_r;
	// every lockout cause; set wins over a clearing command
	wire lock_set = cs_lock || rate_trip || shots_spent || ext_spent;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lockout <= 1'b0;
		end else if (lock_set) begin
			lockout <= 1'b1;
		end else if (clr_lock) begin
			lockout <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset || ar_expire || clr_lock) begin
			shot_count <= 3'h0; // timer expiry or the clear-lockout command clears
		end else if ((own_shot || ext_reclose) && shot_count != 3'h7) begin
			shot_count <= count_inc;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset || ar_expire || clr_lock) begin
			cs_limit_r <= 3'h4;
		end else if (trip_start && cs_en_r && cs_derived < cs_limit_r) begin
			cs_limit_r <= cs_derived; // only ever lowers
		end
	end
	// registered outputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shot_limit <= arsup_pkg::RST_SHOTS;
			next_shot_apply <= 1'b0;
		end else begin
			shot_limit <= eff_limit;
			next_shot_apply <= ext_reclose;
		end
	end
	assign reset_timer_run = ar_run_r;

	////////////////////////////////////////////////////////////////////////
	// read data captured in setup so the access phase answers at once
	wire [31:0] ctrl_rd = {19'h0_0000, relay_sel_r, max_shots_r, zc_en_r,
		oclo_en_r, cs_en_r, mode_r};
	wire [31:0] stat_rd = {(16 - CW)'(0), rate_count, 6'h00, rate_alarm,
		lockout, 1'b0, shot_limit, 1'b0, shot_count};
	wire [31:0] rd_mux = a_ctrl ? ctrl_rd :
		a_rate ? {26'h000_0000, max_rate_r} :
		a_cs3 ? {20'h0_0000, cs3_r} :
		a_cs2 ? {20'h0_0000, cs2_r} :
		a_cs1 ? {20'h0_0000, cs1_r} :
		a_cslo ? {20'h0_0000, cslo_r} :
		a_zcph ? {20'h0_0000, zc_ph_r} :
		a_zcn ? {20'h0_0000, zc_n_r} :
		a_tmax ? {22'h00_0000, zc_tmax_r} :
		a_arr ? {22'h00_0000, ar_reset_r} :
		a_stat ? stat_rd : 32'h0000_0000;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks beside the logic, all on the one system clock
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_rate_lock: assert property (
		rate_trip |=> lockout) else $error("rate excess without lockout");
	a_rate_range: assert property (
		max_rate_r >= 6'h01 && max_rate_r <= 6'h32)
		else $error("max rate out of range");
	a_relay_drive: assert property (
		(rate_op && relay_sel_r != 5'h00) |=> aux_relay != 5'h00)
		else $error("rate relays not driven");
	a_cs_off: assert property (
		(!cs_en_r && !ar_expire && !clr_lock) |=> $stable(cs_limit_r))
		else $error("limit moved while supervision off");
	a_limit_min: assert property (
		shot_limit <= $past(max_shots_r) && shot_limit <= $past(cs_limit_r))
		else $error("effective limit not the minimum");
	// software may clear at once, so the hold allows for that command
	a_cs_lock: assert property (
		cs_lock |=> lockout ##1 (lockout || $past(clr_lock)))
		else $error("current lockout lost");
	a_no_raise: assert property (
		(!ar_expire && !clr_lock) |=> cs_limit_r <= $past(cs_limit_r))
		else $error("current limit rose");
	a_ext_shot: assert property (
		(ext_reclose && !clr_lock && !ar_expire && shot_count < 3'h7) |=>
		shot_count == $past(shot_count) + 3'h1 && next_shot_apply &&
		reset_timer_run) else $error("external reclose not counted");
	a_ext_max: assert property (
		ext_spent |=> lockout) else $error("shot maximum without lockout");
endmodule // arsup_top

/* File: design/arsup_pkg.sv */
// constants and types for the autoreclose supervision block
// Contract
// - rate above maximum forces lockout
// - maximum rate is 1 to 50 per hour
// - rate mode: off, alarm, latched, control
// - operating rate element drives selected relays 3-7
// - current supervision has an enable
// - peak phase current compared after sequence start
// - three thresholds cut shots to three, two, one
// - effective limit is smaller of both limits
// - current lockout overrides every other outcome
// - current limit may fall, never rise
// - current above lockout threshold locks out directly
// - zone coordination has an enable
// - step rise then step fall is external reclose
// - external reclose advances shot, starts reset timer
// - external shots reaching maximum cause lockout
// - reset timer alone clears advanced shot count (the clear-lockout command also clears it)
// - phase step 0.05 to 20.00 times CT
// - neutral step set independently, same range
// - unmatched rise discarded after clearing time
// - maximum shots 1 to 4
// - reset timer expiry returns scheme to start
package arsup_pkg;
	// timing base
	localparam int CLK_PERIOD_NS = 8;
	localparam int SECOND_NS = 1_000_000_000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int RATE_WINDOW_S = 3600;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RATE = 8'h04;
	localparam logic [7:0] OFF_CS3 = 8'h08;
	localparam logic [7:0] OFF_CS2 = 8'h0c;
	localparam logic [7:0] OFF_CS1 = 8'h10;
	localparam logic [7:0] OFF_CSLO = 8'h14;
	localparam logic [7:0] OFF_ZC_PH = 8'h18;
	localparam logic [7:0] OFF_ZC_N = 8'h1c;
	localparam logic [7:0] OFF_ZC_TMAX = 8'h20;
	localparam logic [7:0] OFF_AR_RESET = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;
	localparam logic [7:0] OFF_CMD = 8'h2c;
	// control and command field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CS_EN = 2;
	localparam int CTRL_OCLO_EN = 3;
	localparam int CTRL_ZC_EN = 4;
	localparam int CTRL_SHOTS_LSB = 5;
	localparam int CTRL_RELAY_LSB = 8;
	localparam int CMD_CLR_ALARM = 0;
	localparam int CMD_CLR_LOCKOUT = 1;
	// status field positions
	localparam int ST_SHOTS_LSB = 0;
	localparam int ST_LIMIT_LSB = 4;
	localparam int ST_LOCKOUT = 8;
	localparam int ST_ALARM = 9;
	localparam int ST_RATE_LSB = 16;
	// reset values
	localparam logic [2:0] RST_SHOTS = 3'h1;
	localparam logic [5:0] RST_MAX_RATE = 6'h19;
	localparam logic [11:0] RST_CS3 = 12'h6a4;
	localparam logic [11:0] RST_CS2 = 12'h708;
	localparam logic [11:0] RST_CS1 = 12'h76c;
	localparam logic [11:0] RST_CSLO = 12'h7d0;
	localparam logic [11:0] RST_ZC_STEP = 12'h064;
	localparam logic [9:0] RST_ZC_TMAX = 10'h00a;
	localparam logic [9:0] RST_AR_RESET = 10'h03c;
	// setting ranges
	localparam int RATE_MIN = 1;
	localparam int RATE_MAX = 50;
	localparam int THR_MAX = 2000;
	localparam int STEP_MIN = 5;
	localparam int TIME_MIN = 1;
	localparam int TIME_MAX = 1000;
	localparam int SHOTS_MIN = 1;
	localparam int SHOTS_MAX = 4;
	// rate supervision modes
	typedef enum logic [1:0] {
		RATE_OFF = 2'h0,
		RATE_ALARM = 2'h1,
		RATE_LATCHED = 2'h2,
		RATE_CONTROL = 2'h3
	} arsup_rate_mode_e;
	// coordination detector states, one-hot
	typedef enum logic [1:0] {
		ZC_IDLE = 2'h1,
		ZC_RISEN = 2'h2
	} arsup_zc_state_e;
endpackage

/* File: test/arsup_feeder_model.sv */
// partner model: feeder currents as the relay measures them
`timescale 1ns/1ps
module arsup_feeder_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [1:0] fsel,
	input wire logic [11:0] flt_ph,
	input wire logic [11:0] flt_n,
	output logic [11:0] cur_a,
	output logic [11:0] cur_b,
	output logic [11:0] cur_c,
	output logic [11:0] cur_n,
	output logic meas_valid
);
	// steady load current under every phase
	localparam logic [11:0] LOAD = 12'h032;
	logic [1:0] div_r; // measurement divider
	////////////////////////////////////////////////////////////////////////
	// fault current lands on the selected phase only
	assign cur_a = LOAD + ((fsel == 2'h0) ? flt_ph : 12'h000);
	assign cur_b = LOAD + ((fsel == 2'h1) ? flt_ph : 12'h000);
	assign cur_c = LOAD + ((fsel == 2'h2) ? flt_ph : 12'h000);
	// neutral carries only the earth fault part
	assign cur_n = flt_n;
	// a new sample every fourth cycle, so steps show within one sample
	assign meas_valid = (div_r == 2'h3);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
endmodule // arsup_feeder_model

/* File: test/tb_autoreclose_supervision.sv */
// self-checking bench for the autoreclose supervision block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_autoreclose_supervision;
	localparam int SC = 4; // short second keeps the hour reachable
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} arsup_exp_s;
	localparam logic [11:0] CV [5] = '{12'h6ae, 12'h712, 12'h6ae, 12'h776,
		12'h7da}; // fault currents just above each threshold
	localparam logic [2:0] LV [5] = '{3'h3, 3'h2, 3'h2, 3'h1, 3'h1};
	localparam logic [31:0] RE [4] = '{32'h0002_0000, 32'h0003_0200,
		32'h0004_0200, 32'h0005_0100};
	localparam logic [31:0] RM [4] = '{32'h007f_0300, 32'h007f_0300,
		32'h007f_0200, 32'h007f_0100};
	arsup_exp_s exp_q[$]; // expected read results, oldest first
	arsup_exp_s ex;
	int fails = 0;
	int n_checks = 0;
	int n_ext = 0; // next-settings pulses seen
	logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, meas_valid, trip_start = 0, reclose_done = 0;
	logic [1:0] fsel = 2'h0;
	logic [11:0] flt_ph = 12'h000, flt_n = 12'h000;
	logic [11:0] cur_a, cur_b, cur_c, cur_n;
	logic lockout, next_shot_apply, reset_timer_run, rate_alarm;
	logic [2:0] shot_count, shot_limit;
	logic [4:0] aux_relay;
	////////////////////////////////////////////////////////////////////////
	arsup_top #(.SECOND_CYCLES(SC)) arsup_top_inst (.sys_clk, .reset, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cur_a, .cur_b, .cur_c, .cur_n, .meas_valid, .trip_start,
		.reclose_done, .lockout, .shot_count, .shot_limit, .rate_alarm,
		.aux_relay, .next_shot_apply, .reset_timer_run);
	arsup_feeder_model arsup_feeder_model_inst (.sys_clk, .reset, .fsel,
		.flt_ph, .flt_n, .cur_a, .cur_b, .cur_c, .cur_n, .meas_valid);
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	// apb master: request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m = 32'hffff_ffff,
		input logic e = 1'b0);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back('{d, m, e});
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// status read after the event has settled
	task automatic st(input logic [31:0] d, input logic [31:0] m);
		repeat (3) @(posedge sys_clk);
		apb(1'b0, arsup_pkg::OFF_STATUS, d, m);
	endtask
	// trip with the fault on a random phase
	task automatic trip(input logic [11:0] v);
		fsel <= 2'($urandom % 3);
		flt_ph <= v - 12'h032;
		@(posedge sys_clk);
		trip_start <= 1'b1;
		@(posedge sys_clk);
		trip_start <= 1'b0;
	endtask
	task automatic recl();
		@(posedge sys_clk);
		reclose_done <= 1'b1;
		@(posedge sys_clk);
		reclose_done <= 1'b0;
	endtask
	// downstream recloser: current step up, then its opening drops it
	task automatic ext(input logic nu, input int hold);
		if (nu) flt_n <= 12'h050;
		else flt_ph <= 12'h12c;
		repeat (hold) @(posedge sys_clk);
		flt_n <= 12'h000;
		flt_ph <= 12'h000;
		repeat (12) @(posedge sys_clk);
	endtask
	task automatic print_verdict();
		if (fails == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// monitor: each completed read is matched to the oldest note
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			ex = exp_q.pop_front();
			`CHK(prdata & ex.m, ex.d) // read value
			`CHK(pslverr, ex.e) // bus error
		end
		if (next_shot_apply === 1'b1) n_ext++;
	end
	// watchdog: the full run needs well under this
	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(25332));
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		// reset values and an unmapped place
		apb(0, arsup_pkg::OFF_CTRL, 32'h0000_0020);
		apb(0, arsup_pkg::OFF_RATE, 32'h0000_0019);
		apb(0, arsup_pkg::OFF_CS3, 32'h0000_06a4);
		apb(0, arsup_pkg::OFF_AR_RESET, 32'h0000_003c);
		apb(0, 8'h30, 32'h0000_0000, 32'hffff_ffff, 1'b1);
		st(32'h0000_0010, 32'hffff_ffff);
		// rate setting clamps at both ends
		apb(1, arsup_pkg::OFF_RATE, 32'h0000_0000);
		apb(0, arsup_pkg::OFF_RATE, 32'h0000_0001);
		apb(1, arsup_pkg::OFF_RATE, 32'h0000_003c);
		apb(0, arsup_pkg::OFF_RATE, 32'h0000_0032);
		// step and lockout thresholds clamp too, defaults restored
		apb(1, arsup_pkg::OFF_ZC_PH, 32'h0000_0000);
		apb(0, arsup_pkg::OFF_ZC_PH, 32'h0000_0005);
		apb(1, arsup_pkg::OFF_ZC_PH, 32'h0000_0064);
		apb(1, arsup_pkg::OFF_CSLO, 32'h0000_ffff);
		apb(0, arsup_pkg::OFF_CSLO, 32'h0000_07d0);
		// current supervision: limit only falls
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_0084);
		for (int i = 0; i < 5; i++) begin
			trip(CV[i] + 12'($urandom % 40));
			st({25'h0, LV[i], 4'h0}, 32'h0000_0170);
		end
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_008c);
		trip(CV[4] + 12'($urandom % 40));
		st(32'h0000_0100, 32'h0000_0100);
		apb(1, arsup_pkg::OFF_CMD, 32'h0000_0002);
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_0080);
		trip(CV[3]);
		st(32'h0000_0040, 32'h0000_0170);
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_0044);
		trip(CV[0]);
		st(32'h0000_0020, 32'h0000_0170);
		// zone coordination, once the trips' reset timer has run out
		flt_ph <= 12'h000;
		apb(1, arsup_pkg::OFF_CMD, 32'h0000_0002);
		repeat (250) @(posedge sys_clk);
		`CHK(reset_timer_run, 1'b0)
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_0060);
		apb(1, arsup_pkg::OFF_ZC_N, 32'h0000_0032);
		ext(0, 12);
		st(32'h0000_0000, 32'h0000_0107);
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_0070);
		apb(1, arsup_pkg::OFF_ZC_TMAX, 32'h0000_0001);
		ext(0, 24);
		st(32'h0000_0000, 32'h0000_0107);
		apb(1, arsup_pkg::OFF_ZC_TMAX, 32'h0000_000a);
		ext(0, 12);
		st(32'h0000_0001, 32'h0000_0107);
		`CHK(reset_timer_run, 1'b1)
		`CHK(n_ext, 1)
		ext(1, 12);
		st(32'h0000_0002, 32'h0000_0107);
		repeat (300) @(posedge sys_clk);
		st(32'h0000_0000, 32'h0000_0107);
		`CHK(reset_timer_run, 1'b0)
		ext(0, 12);
		ext(1, 12);
		st(32'h0000_0002, 32'h0000_0107);
		ext(0, 12);
		st(32'h0000_0100, 32'h0000_0100);
		// rate supervision in every mode, then the hour runs out
		apb(1, arsup_pkg::OFF_CMD, 32'h0000_0002);
		apb(1, arsup_pkg::OFF_RATE, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			apb(1, arsup_pkg::OFF_CTRL, {19'h0, 5'h15, 3'h1, 3'h0, 2'(i)});
			recl();
			if (i == 0) recl();
			st(RE[i], RM[i]);
			if (i == 1) `CHK(aux_relay, 5'h15)
		end
		apb(1, arsup_pkg::OFF_CTRL, 32'h0000_1522);
		apb(1, arsup_pkg::OFF_CMD, 32'h0000_0002);
		repeat (3602 * SC) @(posedge sys_clk);
		st(32'h0000_0200, 32'h007f_0200);
		apb(1, arsup_pkg::OFF_CMD, 32'h0000_0001);
		st(32'h0000_0000, 32'h0000_0200);
		print_verdict();
	end
endmodule // tb_autoreclose_supervision
